// *** logic/etc_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------
// Shared constants of the edge triggered travel control
// ----------------------------------------------------------------
package etc_pkg;
  // Clock and filter timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SWITCH_DEB_NS = 10000000;
  localparam int LOGIC_DEB_NS = 1000;
  localparam int STEP_DEB_NS = 20;
  localparam int SWITCH_DEB_CYCLES = (SWITCH_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOGIC_DEB_CYCLES = (LOGIC_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_DEB_CYCLES = (STEP_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_W = 20;
  // Bus and data widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SPEED_W = 12;
  localparam int POS_W = 32;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_POLARITY = 8'h81;
  localparam logic [7:0] IDX_ANALOG_TYPE = 8'h84;
  localparam logic [7:0] IDX_LEVEL_TYPE = 8'h85;
  localparam logic [7:0] IDX_INPUT_TYPE = 8'h9a;
  localparam logic [7:0] IDX_CTRL_TYPE = 8'h9b;
  localparam logic [7:0] IDX_TOTAL_TRAVEL = 8'ha2;
  localparam logic [7:0] IDX_STATUS = 8'hc0;
  localparam logic [7:0] IDX_POSITION = 8'hc1;
  // Field codes
  localparam logic [7:0] POL_FALLING = 8'h02;
  localparam logic [7:0] POL_RISING = 8'h03;
  localparam logic [7:0] LEVEL_SWITCH = 8'h00;
  localparam logic [7:0] ANALOG_SINGLE = 8'h00;
  localparam logic [7:0] INPUT_ANALOG = 8'h02;
  localparam logic [7:0] CTRL_POSITION = 8'h04;
  // Reset values
  localparam logic [7:0] RST_POLARITY = 8'h02;
  localparam logic [7:0] RST_LEVEL_TYPE = 8'h00;
  localparam logic [7:0] RST_ANALOG_TYPE = 8'h00;
  localparam logic [7:0] RST_INPUT_TYPE = 8'h02;
  localparam logic [7:0] RST_CTRL_TYPE = 8'h00;
  localparam logic [31:0] RST_TOTAL_TRAVEL = 32'h0000_1000;
  // Status field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_ACTIVE_BIT = 3;
  localparam int ST_FLIM_BIT = 4;
  localparam int ST_RLIM_BIT = 5;
  localparam int ST_FWD_LVL_BIT = 6;
  localparam int ST_REV_LVL_BIT = 7;
  // Travel states
  typedef enum logic [1:0]
  {
    ETC_IDLE = 2'b00,
    ETC_FWD = 2'b01,
    ETC_REV = 2'b10
  } etc_state_e;
endpackage
`default_nettype wire

// *** logic/etc_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Two stage synchroniser with a stability filter and edge pulses
// ----------------------------------------------------------------
module etc_debounce #(
  parameter int CNT_W = 20,
  parameter logic IDLE_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Raw pin and filter length
  input wire logic raw,
  input wire logic [CNT_W-1:0] limit,
  // Filtered level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic sync_a;
  logic sync_b;
  logic [CNT_W-1:0] cnt;
  logic settle;

  // Settled once the new level has held for the whole filter length
  assign settle = (sync_b != level) && (cnt >= limit);

  // Synchroniser, the first stage feeds only the second
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_a <= IDLE_LEVEL;
      sync_b <= IDLE_LEVEL;
    end
    else
    begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  // Stability counter, restarts on any bounce
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= '0;
    else if ((sync_b == level) || settle)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  // Filtered level with one pulse per accepted edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      level <= IDLE_LEVEL;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      if (settle)
        level <= sync_b;
      rise <= settle && sync_b;
      fall <= settle && !sync_b;
    end
  end
endmodule
`default_nettype wire

// *** logic/etc_travel_ctrl.sv ***
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module etc_travel_ctrl #(
  parameter logic [19:0] SWITCH_DEB = 20'(etc_pkg::SWITCH_DEB_CYCLES),
  parameter logic [19:0] LOGIC_DEB = 20'(etc_pkg::LOGIC_DEB_CYCLES),
  parameter logic [19:0] STEP_DEB = 20'(etc_pkg::STEP_DEB_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [etc_pkg::ADDR_W-1:0] paddr,
  input wire logic [etc_pkg::DATA_W-1:0] pwdata,
  output logic [etc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Speed code from the analog converter
  input wire logic [etc_pkg::SPEED_W-1:0] speed_analog_input,
  // Trigger, limit and travel step pins
  input wire logic forward_trigger_input,
  input wire logic reverse_trigger_input,
  input wire logic forward_limit_switch_n,
  input wire logic reverse_limit_switch_n,
  input wire logic position_step,
  // Motor command and completion
  output logic motor_run,
  output logic motor_dir,
  output logic [etc_pkg::SPEED_W-1:0] motor_speed,
  output logic completion_output
);
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] polarity;
  logic [7:0] level_type;
  logic [7:0] analog_type;
  logic [7:0] input_type;
  logic [7:0] ctrl_type;
  logic [etc_pkg::POS_W-1:0] total_travel;

  // ----------------------------------------------------------------
  // Internal signals
  // ----------------------------------------------------------------
  etc_pkg::etc_state_e state;
  etc_pkg::etc_state_e next_state;
  logic [etc_pkg::POS_W-1:0] position;
  logic [etc_pkg::DEB_W-1:0] trig_limit;
  logic fwd_lvl;
  logic fwd_rise;
  logic fwd_fall;
  logic rev_lvl;
  logic rev_rise;
  logic rev_fall;
  logic flim_lvl;
  logic rlim_lvl;
  logic step_rise;
  logic pol_falling;
  logic pol_rising;
  logic mode_active;
  logic trig_fwd;
  logic trig_rev;
  logic flim_hit;
  logic rlim_hit;
  logic at_fwd_end;
  logic at_rev_end;
  logic [etc_pkg::IDX_W-1:0] idx;
  logic addr_hit;
  logic addr_ro;
  logic apb_setup;
  logic apb_wr;
  logic [etc_pkg::DATA_W-1:0] rd_mux;
  logic [etc_pkg::DATA_W-1:0] status_word;

  // ----------------------------------------------------------------
  // Input filtering
  // ----------------------------------------------------------------
  // Switch contacts need a long filter, logic levels a short one
  assign trig_limit = (level_type == etc_pkg::LEVEL_SWITCH) ? SWITCH_DEB : LOGIC_DEB;

  // Forward trigger filter
  etc_debounce #(.CNT_W(etc_pkg::DEB_W), .IDLE_LEVEL(1'b1)) u_fwd_deb (
    .clk(clk),
    .rstn(rstn),
    .raw(forward_trigger_input),
    .limit(trig_limit),
    .level(fwd_lvl),
    .rise(fwd_rise),
    .fall(fwd_fall)
  );

  // Reverse trigger filter
  etc_debounce #(.CNT_W(etc_pkg::DEB_W), .IDLE_LEVEL(1'b1)) u_rev_deb (
    .clk(clk),
    .rstn(rstn),
    .raw(reverse_trigger_input),
    .limit(trig_limit),
    .level(rev_lvl),
    .rise(rev_rise),
    .fall(rev_fall)
  );

  // Forward limit filter, first limit switch
  etc_debounce #(.CNT_W(etc_pkg::DEB_W), .IDLE_LEVEL(1'b1)) u_flim_deb (
    .clk(clk),
    .rstn(rstn),
    .raw(forward_limit_switch_n),
    .limit(LOGIC_DEB),
    .level(flim_lvl),
    .rise(),
    .fall()
  );

  // Reverse limit filter, second limit switch
  etc_debounce #(.CNT_W(etc_pkg::DEB_W), .IDLE_LEVEL(1'b1)) u_rlim_deb (
    .clk(clk),
    .rstn(rstn),
    .raw(reverse_limit_switch_n),
    .limit(LOGIC_DEB),
    .level(rlim_lvl),
    .rise(),
    .fall()
  );

  // Travel step pulses from the motor feedback
  etc_debounce #(.CNT_W(etc_pkg::DEB_W), .IDLE_LEVEL(1'b0)) u_step_deb (
    .clk(clk),
    .rstn(rstn),
    .raw(position_step),
    .limit(STEP_DEB),
    .level(),
    .rise(step_rise),
    .fall()
  );

  // ----------------------------------------------------------------
  // Trigger qualification
  // ----------------------------------------------------------------
  // Mode is live only with analog input, single ended, position loop
  assign mode_active = (input_type == etc_pkg::INPUT_ANALOG)
    && (analog_type == etc_pkg::ANALOG_SINGLE)
    && (ctrl_type == etc_pkg::CTRL_POSITION);
  assign pol_falling = (polarity == etc_pkg::POL_FALLING);
  assign pol_rising = (polarity == etc_pkg::POL_RISING);

  // A closed contact pulls the pin low, so both input types act alike
  assign trig_fwd = mode_active
    && ((pol_falling && fwd_fall && rev_lvl)
    || (pol_rising && fwd_rise && !rev_lvl));
  assign trig_rev = mode_active
    && ((pol_falling && rev_fall && fwd_lvl)
    || (pol_rising && rev_rise && !fwd_lvl));

  // Limit switches close to common when reached
  assign flim_hit = !flim_lvl;
  assign rlim_hit = !rlim_lvl;
  assign at_fwd_end = flim_hit || (position >= total_travel);
  assign at_rev_end = rlim_hit || (position == '0);

  // ----------------------------------------------------------------
  // Travel state machine
  // ----------------------------------------------------------------
  // Next state, a new trigger may retarget a running travel
  always_comb
  begin
    next_state = state;
    case (state)
      etc_pkg::ETC_IDLE:
      begin
        if (trig_fwd && !at_fwd_end)
          next_state = etc_pkg::ETC_FWD;
        else if (trig_rev && !at_rev_end)
          next_state = etc_pkg::ETC_REV;
      end
      etc_pkg::ETC_FWD:
      begin
        if (!mode_active)
          next_state = etc_pkg::ETC_IDLE;
        else if (trig_rev && !at_rev_end)
          next_state = etc_pkg::ETC_REV;
        else if (at_fwd_end)
          next_state = etc_pkg::ETC_IDLE;
      end
      etc_pkg::ETC_REV:
      begin
        if (!mode_active)
          next_state = etc_pkg::ETC_IDLE;
        else if (trig_fwd && !at_fwd_end)
          next_state = etc_pkg::ETC_FWD;
        else if (at_rev_end)
          next_state = etc_pkg::ETC_IDLE;
      end
      default:
        next_state = etc_pkg::ETC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state <= etc_pkg::ETC_IDLE;
    else
      state <= next_state;
  end

  // Completion flag, cleared by a new travel, set at its end unless the mode is no longer live
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      completion_output <= 1'b0;
    else if ((state != etc_pkg::ETC_IDLE) && (next_state == etc_pkg::ETC_IDLE) && mode_active)
      completion_output <= 1'b1;
    else if ((next_state != state) && (next_state != etc_pkg::ETC_IDLE))
      completion_output <= 1'b0;
  end

  // Position counter, homed at the reverse limit; the filtered limit lags the
  // pin, so a forward travel leaving the limit must not lose its first step
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      position <= '0;
    else if (rlim_hit && (state != etc_pkg::ETC_FWD))
      position <= '0;
    else if (step_rise && (state == etc_pkg::ETC_FWD) && (position != '1))
      position <= position + 1'b1;
    else if (step_rise && (state == etc_pkg::ETC_REV) && (position != '0))
      position <= position - 1'b1;
  end

  // Motor command, speed only while travelling
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      motor_run <= 1'b0;
      motor_dir <= 1'b0;
      motor_speed <= '0;
    end
    else
    begin
      motor_run <= (next_state != etc_pkg::ETC_IDLE);
      motor_dir <= (next_state == etc_pkg::ETC_FWD);
      motor_speed <= (next_state != etc_pkg::ETC_IDLE) ? speed_analog_input : '0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Decode, one wait state before pready
  assign idx = paddr[etc_pkg::IDX_LSB +: etc_pkg::IDX_W];
  assign apb_setup = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;
  assign addr_ro = (idx == etc_pkg::IDX_STATUS) || (idx == etc_pkg::IDX_POSITION);
  assign addr_hit = (paddr[etc_pkg::IDX_LSB-1:0] == '0)
    && (paddr[etc_pkg::ADDR_W-1:etc_pkg::IDX_LSB+etc_pkg::IDX_W] == '0) && (addr_ro
    || (idx == etc_pkg::IDX_POLARITY) || (idx == etc_pkg::IDX_ANALOG_TYPE)
    || (idx == etc_pkg::IDX_LEVEL_TYPE) || (idx == etc_pkg::IDX_INPUT_TYPE)
    || (idx == etc_pkg::IDX_CTRL_TYPE) || (idx == etc_pkg::IDX_TOTAL_TRAVEL));

  // Status word built from live state
  always_comb
  begin
    status_word = '0;
    status_word[etc_pkg::ST_STATE_LSB +: 2] = state;
    status_word[etc_pkg::ST_DONE_BIT] = completion_output;
    status_word[etc_pkg::ST_ACTIVE_BIT] = mode_active;
    status_word[etc_pkg::ST_FLIM_BIT] = flim_hit;
    status_word[etc_pkg::ST_RLIM_BIT] = rlim_hit;
    status_word[etc_pkg::ST_FWD_LVL_BIT] = fwd_lvl;
    status_word[etc_pkg::ST_REV_LVL_BIT] = rev_lvl;
  end

  // Read multiplexer, narrow fields in the low bits
  always_comb
  begin
    rd_mux = '0;
    case (idx)
      etc_pkg::IDX_POLARITY: rd_mux = {24'h00_0000, polarity};
      etc_pkg::IDX_ANALOG_TYPE: rd_mux = {24'h00_0000, analog_type};
      etc_pkg::IDX_LEVEL_TYPE: rd_mux = {24'h00_0000, level_type};
      etc_pkg::IDX_INPUT_TYPE: rd_mux = {24'h00_0000, input_type};
      etc_pkg::IDX_CTRL_TYPE: rd_mux = {24'h00_0000, ctrl_type};
      etc_pkg::IDX_TOTAL_TRAVEL: rd_mux = total_travel;
      etc_pkg::IDX_STATUS: rd_mux = status_word;
      etc_pkg::IDX_POSITION: rd_mux = position;
      default: rd_mux = '0;
    endcase
  end

  // Answer phase: ready, error and read data from flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_hit;
      if (apb_setup && !pwrite && addr_hit)
        prdata <= rd_mux;
      else if (apb_setup)
        prdata <= '0;
    end
  end

  // Configuration writes, read-only words ignore writes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      polarity <= etc_pkg::RST_POLARITY;
      analog_type <= etc_pkg::RST_ANALOG_TYPE;
      level_type <= etc_pkg::RST_LEVEL_TYPE;
      input_type <= etc_pkg::RST_INPUT_TYPE;
      ctrl_type <= etc_pkg::RST_CTRL_TYPE;
      total_travel <= etc_pkg::RST_TOTAL_TRAVEL;
    end
    else if (apb_wr)
    begin
      case (idx)
        etc_pkg::IDX_POLARITY: polarity <= pwdata[7:0];
        etc_pkg::IDX_ANALOG_TYPE: analog_type <= pwdata[7:0];
        etc_pkg::IDX_LEVEL_TYPE: level_type <= pwdata[7:0];
        etc_pkg::IDX_INPUT_TYPE: input_type <= pwdata[7:0];
        etc_pkg::IDX_CTRL_TYPE: ctrl_type <= pwdata[7:0];
        etc_pkg::IDX_TOTAL_TRAVEL: total_travel <= pwdata;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verification/etc_travel_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module etc_travel_ctrl_chk #(
  parameter logic [19:0] SWITCH_DEB = 20'h00008,
  parameter logic [19:0] LOGIC_DEB = 20'h00004,
  parameter logic [19:0] STEP_DEB = 20'h00001
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [etc_pkg::ADDR_W-1:0] paddr,
  input wire logic [etc_pkg::DATA_W-1:0] pwdata,
  input wire logic [etc_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic [etc_pkg::SPEED_W-1:0] speed_analog_input,
  input wire logic forward_trigger_input,
  input wire logic reverse_trigger_input,
  input wire logic forward_limit_switch_n,
  input wire logic reverse_limit_switch_n,
  input wire logic position_step,
  input wire logic motor_run,
  input wire logic motor_dir,
  input wire logic [etc_pkg::SPEED_W-1:0] motor_speed,
  input wire logic completion_output
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_SPEED_FOLLOW: assert property (motor_run && $past(motor_run) && $stable(speed_analog_input)
    |-> motor_speed == speed_analog_input) else $error("speed not following input");
  AST_SPEED_IDLE: assert property (!motor_run && !$past(motor_run) |-> motor_speed == 12'h000)
    else $error("speed while stopped");
  AST_FWD_LIMIT: assert property ($fell(forward_limit_switch_n) && motor_run && motor_dir
    |-> ##[1:40] !motor_run) else $error("no stop at forward limit");
  AST_REV_LIMIT: assert property ($fell(reverse_limit_switch_n) && motor_run && !motor_dir
    |-> ##[1:40] !motor_run) else $error("no stop at reverse limit");
  AST_START_FWD: assert property ($rose(motor_run) && motor_dir |-> forward_limit_switch_n)
    else $error("forward start at limit");
  AST_START_REV: assert property ($rose(motor_run) && !motor_dir |-> reverse_limit_switch_n)
    else $error("reverse start at limit");
  AST_DONE_AT_STOP: assert property ($fell(motor_run) |-> completion_output)
    else $error("stop without completion");
  AST_DONE_CLEAR: assert property ($rose(motor_run) |-> !completion_output)
    else $error("completion kept on start");
  AST_DONE_HOLD: assert property (completion_output && !motor_run |=> completion_output || motor_run)
    else $error("completion dropped while idle");
  AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready)
    else $error("late register answer");
endmodule
bind etc_travel_ctrl etc_travel_ctrl_chk #(.SWITCH_DEB(SWITCH_DEB), .LOGIC_DEB(LOGIC_DEB),
  .STEP_DEB(STEP_DEB)) etc_travel_ctrl_chk_inst (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .speed_analog_input(speed_analog_input),
  .forward_trigger_input(forward_trigger_input), .reverse_trigger_input(reverse_trigger_input),
  .forward_limit_switch_n(forward_limit_switch_n), .reverse_limit_switch_n(reverse_limit_switch_n),
  .position_step(position_step), .motor_run(motor_run), .motor_dir(motor_dir),
  .motor_speed(motor_speed), .completion_output(completion_output));
`default_nettype wire

// *** verification/etc_limit_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module etc_limit_model #(
  parameter int FLIM = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Motor command
  input wire logic motor_run,
  input wire logic motor_dir,
  // Step and limit pins
  output logic position_step,
  output logic forward_limit_switch_n,
  output logic reverse_limit_switch_n
);
  logic [2:0] phase;
  int pos;
  // Step phase turns only with the motor; position moves at each step rise
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase <= 3'h0;
      pos <= 0;
    end
    else if (motor_run)
    begin
      phase <= phase + 3'h1;
      if (phase == 3'h3 && motor_dir)
        pos <= pos + 1;
      else if (phase == 3'h3 && pos > 0)
        pos <= pos - 1;
    end
  end
  // Step pin, eight cycles a step
  assign position_step = phase[2];
  // First switch bounds forward travel, second sits at the start
  assign forward_limit_switch_n = (pos < FLIM);
  assign reverse_limit_switch_n = (pos > 0);
endmodule
`default_nettype wire

// *** verification/etc_travel_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module etc_travel_ctrl_tb;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, fwd_pin, rev_pin, idle;
  logic step, flim_n, rlim_n, motor_run, motor_dir, completion_output;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] spd, motor_speed;
  int error_cnt, compares;
  logic [7:0] ridx [7] = '{8'h81, 8'h84, 8'h85, 8'h9a, 8'h9b, 8'ha2, 8'hc1};
  logic [31:0] rval [7] = '{32'h2, 32'h0, 32'h0, 32'h2, 32'h0, 32'h1000, 32'h0};
  logic [7:0] pols [4] = '{8'h02, 8'h02, 8'h03, 8'h03};
  logic [7:0] lvls [4] = '{8'h00, 8'h01, 8'h00, 8'h01};
  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  etc_travel_ctrl #(.SWITCH_DEB(20'h00008), .LOGIC_DEB(20'h00004), .STEP_DEB(20'h00001))
    etc_travel_ctrl_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .speed_analog_input(spd), .forward_trigger_input(fwd_pin),
    .reverse_trigger_input(rev_pin), .forward_limit_switch_n(flim_n),
    .reverse_limit_switch_n(rlim_n), .position_step(step), .motor_run(motor_run),
    .motor_dir(motor_dir), .motor_speed(motor_speed), .completion_output(completion_output));
  etc_limit_model #(.FLIM(20)) etc_limit_model_inst (.clk(clk), .rstn(rstn),
    .motor_run(motor_run), .motor_dir(motor_dir), .position_step(step),
    .forward_limit_switch_n(flim_n), .reverse_limit_switch_n(rlim_n));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s is %b", $time, what, got);
    end
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_pin(n == 2, 1'b1, "pready latency");
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, {2'h0, idx, 2'h0}, d, rd, err);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk_reg(rd, exp);
    chk_pin(err, experr, "pslverr");
  endtask
  // Trigger pin leaves its idle level for len cycles
  task automatic pulse(input logic fwd, input int len);
    if (fwd)
      fwd_pin <= !idle;
    else
      rev_pin <= !idle;
    repeat (len) @(posedge clk);
    fwd_pin <= idle;
    rev_pin <= idle;
  endtask
  task automatic norun(input logic fwd, input int len);
    pulse(fwd, len);
    repeat (25) @(posedge clk);
    chk_pin(motor_run, 1'b0, "run without command");
  endtask
  task automatic set_mode(input logic [7:0] pol, input logic [7:0] lvl);
    wr(8'h81, {24'h0, pol});
    wr(8'h85, {24'h0, lvl});
    idle = (pol == etc_pkg::POL_FALLING);
    fwd_pin <= idle;
    rev_pin <= idle;
    repeat (30) @(posedge clk);
  endtask
  // One commanded travel and its stop
  task automatic travel(input logic fwd, input logic [31:0] pos, input logic chkpos);
    int n;
    pulse(fwd, 20);
    chk_pin(motor_run, 1'b1, "run");
    chk_pin(motor_dir, fwd, "dir");
    chk_pin(completion_output, 1'b0, "completion at start");
    chk_reg(32'(motor_speed), 32'(spd));
    n = 0;
    while (!(completion_output === 1'b1 && motor_run === 1'b0) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk_pin(motor_run, 1'b0, "stop");
    chk_pin(completion_output, 1'b1, "completion");
    if (chkpos)
      rdchk({2'h0, etc_pkg::IDX_POSITION, 2'h0}, pos, 1'b0);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    conclude();
  end
  initial
  begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fwd_pin, rev_pin, idle} = 3'b111;
    spd = 12'h5a3;
    error_cnt = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdchk({2'h0, ridx[i], 2'h0}, rval[i], 1'b0);
    rdchk(12'h000, 32'h0, 1'b1);
    rdchk(12'h206, 32'h0, 1'b1);
    $display("Test register reset values done");
    norun(1'b1, 20);
    wr(etc_pkg::IDX_CTRL_TYPE, 32'h4);
    wr(etc_pkg::IDX_TOTAL_TRAVEL, 32'ha);
    rdchk({2'h0, etc_pkg::IDX_CTRL_TYPE, 2'h0}, 32'h4, 1'b0);
    wr(etc_pkg::IDX_POLARITY, 32'h1);
    norun(1'b1, 20);
    set_mode(etc_pkg::POL_FALLING, etc_pkg::LEVEL_SWITCH);
    norun(1'b1, 3);
    norun(1'b0, 20);
    $display("Test refused triggers done");
    for (int i = 0; i < 4; i++)
    begin
      set_mode(pols[i], lvls[i]);
      spd <= spd + 12'h011;
      travel(1'b1, 32'ha, 1'b1);
      travel(1'b0, 32'h0, 1'b1);
      $display("Test mode %0d done", i);
    end
    set_mode(etc_pkg::POL_FALLING, etc_pkg::LEVEL_SWITCH);
    wr(etc_pkg::IDX_TOTAL_TRAVEL, 32'h32);
    travel(1'b1, 32'h0, 1'b0);
    rdchk({2'h0, etc_pkg::IDX_STATUS, 2'h0}, 32'hdc, 1'b0);
    norun(1'b1, 20);
    travel(1'b0, 32'h0, 1'b1);
    $display("Test limit stop done");
    pulse(1'b1, 20);
    repeat (20) @(posedge clk);
    travel(1'b0, 32'h0, 1'b1);
    $display("Test retarget done");
    conclude();
  end
endmodule
`default_nettype wire
